/* File: verilog/ovp_switch_control.sv */
// switch sequencing, protection lockout, threshold select and detection
`timescale 1ns/1ps
module ovp_switch_control
	import ovp_switch_pkg::*;
#(
	parameter int DEBOUNCE = DEBOUNCE_CYCLES
) (
	// clock and reset
	input  wire logic      i_clock,
	input  wire logic      i_rst_n,
	// analog comparators and pins
	input  wire pins_t     i_pins,
	// converter, same clock
	input  wire logic      i_adc_valid,
	input  wire logic [7:0] i_adc_result,
	// register port from the serial slave
	input  wire reg_req_t  i_reg_req,
	output logic [7:0]     o_reg_rdata,
	output logic           o_reg_rvalid,
	// power stage
	output logic           o_switch_on,
	output logic [2:0]     o_slew_select,
	output logic           o_protect_enable,
	output trip_cfg_t      o_trip,
	// detection front end
	output logic           o_detect_power,
	output logic           o_probe_on,
	output logic [3:0]     o_probe_current,
	// event to interrupt logic
	output logic           o_event
);
	typedef enum {DET_OFF, DET_SLEEP, DET_STANDBY, DET_PULSE,
		DET_CONVERT, DET_REST} det_state_t;

	pins_t       sync1, pins;
	logic        output_switch_enable_bit, next_output_switch_enable_bit, det_en, next_det_en;
	logic [1:0]  coarse, next_coarse, alt, next_alt;
	logic [2:0]  trim, next_trim, slew, next_slew;
	logic [3:0]  probe, next_probe, pulse_code, next_pulse_code;
	logic [3:0]  period_code, next_period_code;
	logic [7:0]  target, next_target, result, next_result;
	logic [2:0]  flags, next_flags;
	logic        from_reg, next_from_reg, strap_taken, next_strap_taken;
	logic        adj_ok, next_adj_ok;
	logic [7:0]  rdata, next_rdata, status;
	logic        rvalid, next_rvalid;
	trip_cfg_t   trip, next_trip;
	logic        en_active, body_diode, ot_active, next_ot_active;
	logic        oc_active, next_oc_active, fault, ready;
	logic        sw_on, next_sw_on;
	logic [DEB_W-1:0] deb, next_deb;
	det_state_t  dstate, next_dstate;
	logic [TICK_W-1:0] tick, next_tick;
	logic [TIMER_W-1:0] timer, next_timer;
	logic [3:0]  prev_probe, next_prev_probe;
	logic        done, next_done, below, next_below;
	logic [7:0]  events, last_events;
	logic        evt, next_evt;
	logic        ov_set, ot_set, oc_set, us_tick;

	// pin synchroniser, not reset, fills while reset is held
	always_ff @(posedge i_clock) begin
		sync1 <= i_pins;
		pins  <= sync1;
	end

	// protection and switch sequencing
	always_comb begin
		en_active  = !pins.en_n;
		body_diode = pins.otg_source && (!en_active || output_switch_enable_bit);
		ov_set = en_active && pins.above_ovlo;
		ot_set = (en_active || pins.otg_source) && pins.temp_hot;
		oc_set = sw_on && pins.fully_on && pins.over_current;
		next_ot_active = ot_active;
		if (!en_active) begin
			next_ot_active = 1'b0;
		end else if (pins.temp_hot) begin
			next_ot_active = 1'b1;
		end else if (pins.temp_cool) begin
			next_ot_active = 1'b0;
		end
		next_oc_active = en_active && (oc_set || (oc_active && pins.over_current));
		// body diode conduction: overtemp only reports
		fault = !pins.above_undervoltage_lockout || pins.above_ovlo
			|| (ot_active && !body_diode) || oc_active;
		ready = en_active && !fault;
		next_deb = '0;
		if (ready) begin
			next_deb = (deb == DEB_W'(DEBOUNCE)) ? deb : deb + 1'b1;
		end
		next_sw_on = ready && (deb == DEB_W'(DEBOUNCE));
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			ot_active <= 1'b0;
			oc_active <= 1'b0;
			deb       <= '0;
			sw_on     <= 1'b0;
		end else begin
			ot_active <= next_ot_active;
			oc_active <= next_oc_active;
			deb       <= next_deb;
			sw_on     <= next_sw_on;
		end
	end

	// register file, flags and threshold source
	always_comb begin
		status = BYTE_RESET;
		status[ST_PWRON] = pins.above_undervoltage_lockout;
		status[ST_BELOW] = below;
		status[ST_DONE]  = done;
		status[ST_SWON]  = sw_on;
		status[ST_OTG]   = pins.otg_source;
		next_output_switch_enable_bit     = output_switch_enable_bit;
		next_det_en      = det_en;
		next_coarse      = coarse;
		next_trim        = trim;
		next_alt         = alt;
		next_slew        = slew;
		next_probe       = probe;
		next_pulse_code  = pulse_code;
		next_period_code = period_code;
		next_target      = target;
		next_from_reg    = from_reg;
		next_strap_taken = 1'b1;
		next_adj_ok      = strap_taken ? adj_ok : pins.adjust_valid;
		if (i_reg_req.write) begin
			case (i_reg_req.addr)
				ADDR_ENABLE: begin
					next_output_switch_enable_bit = i_reg_req.wdata[EN_OUT_BIT];
					next_det_en  = i_reg_req.wdata[EN_DET_BIT];
				end
				ADDR_TRIP: begin
					next_coarse   = i_reg_req.wdata[1:0];
					next_trim     = i_reg_req.wdata[TRIM_LO+:3];
					next_from_reg = 1'b1;
				end
				ADDR_PROBE: next_probe = i_reg_req.wdata[3:0];
				ADDR_TIMING: begin
					next_pulse_code  = i_reg_req.wdata[PULSE_LO+:4];
					next_period_code = i_reg_req.wdata[3:0];
				end
				ADDR_TARGET: next_target = i_reg_req.wdata;
				ADDR_ALT: begin
					next_alt      = i_reg_req.wdata[1:0];
					next_from_reg = 1'b1;
				end
				ADDR_SLEW: next_slew = i_reg_req.wdata[2:0];
				default: next_from_reg = from_reg;
			endcase
		end
		// clear on read or undervoltage, a same-cycle set wins
		next_flags = flags;
		if ((i_reg_req.read && i_reg_req.addr == ADDR_FLAG)
			|| !pins.above_undervoltage_lockout) begin
			next_flags = 3'h0;
		end
		next_flags[FL_OV] = next_flags[FL_OV] || ov_set;
		next_flags[FL_OT] = next_flags[FL_OT] || ot_set;
		next_flags[FL_OC] = next_flags[FL_OC] || oc_set;
		next_rvalid = i_reg_req.read;
		next_rdata  = rdata;
		if (i_reg_req.read) begin
			case (i_reg_req.addr)
				ADDR_ENABLE: next_rdata = {output_switch_enable_bit, det_en, 6'h00};
				ADDR_STATUS: next_rdata = status;
				ADDR_FLAG:   next_rdata = {5'h00, flags};
				ADDR_TRIP:   next_rdata = {1'b0, trim, 2'h0, coarse};
				ADDR_PROBE:  next_rdata = {4'h0, probe};
				ADDR_TIMING: next_rdata = {pulse_code, period_code};
				ADDR_RESULT: next_rdata = result;
				ADDR_TARGET: next_rdata = target;
				ADDR_ALT:    next_rdata = {6'h00, alt};
				ADDR_SLEW:   next_rdata = {5'h00, slew};
				default:     next_rdata = BYTE_RESET;
			endcase
		end
		next_trip.use_pin  = !from_reg && adj_ok;
		next_trip.use_trim = from_reg;
		next_trip.trim     = trim;
		next_trip.level    = {1'b0, coarse};
		if (alt == ALT_10V) begin
			next_trip.level = LEVEL_10V;
		end else if (alt == ALT_14V) begin
			next_trip.level = LEVEL_14V;
		end
		events = {status[7:4], 1'b0, flags};
		next_evt = |(events & ~last_events);
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			output_switch_enable_bit     <= 1'b0;
			det_en      <= 1'b0;
			coarse      <= COARSE_RESET;
			trim        <= TRIM_RESET;
			alt         <= ALT_RESET;
			slew        <= SLEW_RESET;
			probe       <= PROBE_OFF;
			pulse_code  <= 4'h0;
			period_code <= PERIOD_SINGLE;
			target      <= BYTE_RESET;
			flags       <= 3'h0;
			from_reg    <= 1'b0;
			strap_taken <= 1'b0;
			adj_ok      <= 1'b0;
			rdata       <= BYTE_RESET;
			rvalid      <= 1'b0;
			trip        <= '0;
			last_events <= BYTE_RESET;
			evt         <= 1'b0;
		end else begin
			output_switch_enable_bit     <= next_output_switch_enable_bit;
			det_en      <= next_det_en;
			coarse      <= next_coarse;
			trim        <= next_trim;
			alt         <= next_alt;
			slew        <= next_slew;
			probe       <= next_probe;
			pulse_code  <= next_pulse_code;
			period_code <= next_period_code;
			target      <= next_target;
			flags       <= next_flags;
			from_reg    <= next_from_reg;
			strap_taken <= next_strap_taken;
			adj_ok      <= next_adj_ok;
			rdata       <= next_rdata;
			rvalid      <= next_rvalid;
			trip        <= next_trip;
			last_events <= events;
			evt         <= next_evt;
		end
	end

	// impedance detection sequencer
	always_comb begin
		us_tick         = (tick == TICK_W'(US_CYCLES - 1));
		next_tick       = us_tick ? '0 : tick + 1'b1;
		next_timer      = us_tick ? timer + 1'b1 : timer;
		next_dstate     = dstate;
		next_prev_probe = probe;
		next_done       = done;
		next_below      = below;
		next_result     = result;
		case (dstate)
			DET_OFF: if (en_active && !pins.above_undervoltage_lockout)
				next_dstate = DET_SLEEP;
			DET_SLEEP: if (det_en) next_dstate = DET_STANDBY;
			DET_STANDBY: begin
				if (!det_en) begin
					next_dstate = DET_SLEEP;
				end else if (prev_probe == PROBE_OFF && probe != PROBE_OFF) begin
					next_dstate = DET_PULSE;
					next_timer  = '0;
					next_tick   = '0;
					next_done   = 1'b0;
				end
			end
			DET_PULSE: begin
				if (probe == PROBE_OFF) begin
					next_dstate = DET_STANDBY;
				end else if (pulse_code != PULSE_ALWAYS
					&& timer >= pulse_us(pulse_code)) begin
					next_dstate = DET_CONVERT;
				end
			end
			DET_CONVERT: begin
				if (i_adc_valid) begin
					next_result = i_adc_result;
					next_done   = 1'b1;
					next_below  = i_adc_result < target;
					next_dstate = (period_code == PERIOD_SINGLE)
						? DET_STANDBY : DET_REST;
				end
			end
			DET_REST: begin
				if (probe == PROBE_OFF) begin
					next_dstate = DET_STANDBY;
				end else if (timer >= period_us(period_code)) begin
					next_dstate = DET_PULSE;
					next_timer  = '0;
					next_tick   = '0;
					next_done   = 1'b0;
				end
			end
			default: next_dstate = DET_OFF;
		endcase
		if (!en_active || pins.above_undervoltage_lockout) begin
			next_dstate = DET_OFF;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			dstate     <= DET_OFF;
			tick       <= '0;
			timer      <= '0;
			prev_probe <= PROBE_OFF;
			done       <= 1'b0;
			below      <= 1'b0;
			result     <= BYTE_RESET;
		end else begin
			dstate     <= next_dstate;
			tick       <= next_tick;
			timer      <= next_timer;
			prev_probe <= next_prev_probe;
			done       <= next_done;
			below      <= next_below;
			result     <= next_result;
		end
	end
	// outputs from flops
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_switch_on      <= 1'b0;
			o_slew_select    <= SLEW_RESET;
			o_protect_enable <= 1'b0;
			o_detect_power   <= 1'b0;
			o_probe_on       <= 1'b0;
			o_probe_current  <= PROBE_OFF;
		end else begin
			o_switch_on      <= next_sw_on;
			o_slew_select    <= next_slew;
			o_protect_enable <= !pins.en_n;
			o_detect_power   <= next_dstate == DET_STANDBY
				|| next_dstate == DET_PULSE || next_dstate == DET_CONVERT
				|| next_dstate == DET_REST;
			o_probe_on       <= next_dstate == DET_PULSE;
			o_probe_current  <= next_probe;
		end
	end
	assign o_reg_rdata  = rdata;
	assign o_reg_rvalid = rvalid;
	assign o_trip       = trip;
	assign o_event      = evt;
endmodule : ovp_switch_control

/* File: verilog/ovp_switch_pkg.sv */
// constants, types and timing tables for the overvoltage switch control
package ovp_switch_pkg;
	localparam int CLOCK_HZ        = 40_000_000;
	localparam int DEBOUNCE_MS     = 13;
	localparam int DEBOUNCE_CYCLES = CLOCK_HZ / 1000 * DEBOUNCE_MS;
	localparam int US_CYCLES       = CLOCK_HZ / 1_000_000;
	localparam int TIMER_W         = 29;
	localparam int DEB_W           = 20;
	localparam int TICK_W          = 6;

	// register offsets
	localparam logic [7:0] ADDR_ENABLE = 8'h01;
	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_FLAG   = 8'h03;
	localparam logic [7:0] ADDR_TRIP   = 8'h05;
	localparam logic [7:0] ADDR_PROBE  = 8'h06;
	localparam logic [7:0] ADDR_TIMING = 8'h07;
	localparam logic [7:0] ADDR_RESULT = 8'h08;
	localparam logic [7:0] ADDR_TARGET = 8'h09;
	localparam logic [7:0] ADDR_ALT    = 8'h0E;
	localparam logic [7:0] ADDR_SLEW   = 8'h0F;

	// bit positions
	localparam int EN_OUT_BIT = 7;
	localparam int EN_DET_BIT = 6;
	localparam int ST_PWRON   = 7;
	localparam int ST_BELOW   = 6;
	localparam int ST_DONE    = 5;
	localparam int ST_SWON    = 4;
	localparam int ST_OTG     = 3;
	localparam int FL_OV      = 2;
	localparam int FL_OC      = 1;
	localparam int FL_OT      = 0;
	localparam int TRIM_LO    = 4;
	localparam int PULSE_LO   = 4;

	// reset values and codes
	localparam logic [2:0] SLEW_RESET    = 3'h4;
	localparam logic [2:0] TRIM_RESET    = 3'h3;
	localparam logic [1:0] COARSE_RESET  = 2'h0;
	localparam logic [1:0] ALT_RESET     = 2'h0;
	localparam logic [3:0] PROBE_OFF     = 4'h0;
	localparam logic [7:0] BYTE_RESET    = 8'h00;
	localparam logic [3:0] PULSE_ALWAYS  = 4'hF;
	localparam logic [3:0] PERIOD_SINGLE = 4'h0;
	localparam logic [1:0] ALT_10V       = 2'h2;
	localparam logic [1:0] ALT_14V       = 2'h3;
	localparam logic [2:0] LEVEL_10V     = 3'h4;
	localparam logic [2:0] LEVEL_14V     = 3'h5;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic       use_pin;
		logic       use_trim;
		logic [2:0] level;
		logic [2:0] trim;
	} trip_cfg_t;

	typedef struct packed {
		logic en_n;
		logic above_undervoltage_lockout;
		logic above_ovlo;
		logic temp_hot;
		logic temp_cool;
		logic over_current;
		logic fully_on;
		logic otg_source;
		logic adjust_valid;
	} pins_t;

	localparam pins_t PINS_RESET = 9'h100;

	// probe pulse width in microseconds
	function automatic logic [TIMER_W-1:0] pulse_us(input logic [3:0] code);
		case (code)
			4'h0: pulse_us = 29'd200;
			4'h1: pulse_us = 29'd400;
			4'h2: pulse_us = 29'd1000;
			4'h3: pulse_us = 29'd2000;
			4'h4: pulse_us = 29'd4000;
			4'h5: pulse_us = 29'd10000;
			4'h6: pulse_us = 29'd20000;
			4'h7: pulse_us = 29'd40000;
			4'h8: pulse_us = 29'd100000;
			4'h9: pulse_us = 29'd200000;
			4'hA: pulse_us = 29'd400000;
			4'hB: pulse_us = 29'd1000000;
			4'hC: pulse_us = 29'd2000000;
			4'hD: pulse_us = 29'd4000000;
			default: pulse_us = 29'd10000000;
		endcase
	endfunction : pulse_us

	// probe repeat period in microseconds
	function automatic logic [TIMER_W-1:0] period_us(input logic [3:0] code);
		case (code)
			4'h1: period_us = 29'd10000;
			4'h2: period_us = 29'd20000;
			4'h3: period_us = 29'd50000;
			4'h4: period_us = 29'd100000;
			4'h5: period_us = 29'd200000;
			4'h6: period_us = 29'd500000;
			4'h7: period_us = 29'd1000000;
			4'h8: period_us = 29'd2000000;
			4'h9: period_us = 29'd3000000;
			4'hA: period_us = 29'd6000000;
			4'hB: period_us = 29'd12000000;
			4'hC: period_us = 29'd30000000;
			4'hD: period_us = 29'd60000000;
			4'hE: period_us = 29'd120000000;
			4'hF: period_us = 29'd300000000;
			default: period_us = 29'd0;
		endcase
	endfunction : period_us
endpackage : ovp_switch_pkg

/* File: test/ovp_switch_control_props.sv */
// assertion checker for the switch control ports
`timescale 1ns/1ps
module ovp_switch_control_props
	import ovp_switch_pkg::*;
#(
	parameter int DEBOUNCE = DEBOUNCE_CYCLES
) (
	// clock and reset
	input wire logic       i_clock,
	input wire logic       i_rst_n,
	// inputs
	input wire pins_t      i_pins,
	input wire logic       i_adc_valid,
	input wire logic [7:0] i_adc_result,
	input wire reg_req_t   i_reg_req,
	// outputs
	input wire logic [7:0] o_reg_rdata,
	input wire logic       o_reg_rvalid,
	input wire logic       o_switch_on,
	input wire logic [2:0] o_slew_select,
	input wire logic       o_protect_enable,
	input wire trip_cfg_t  o_trip,
	input wire logic       o_detect_power,
	input wire logic       o_probe_on,
	input wire logic [3:0] o_probe_current,
	input wire logic       o_event
);
	logic [31:0] ready_cnt;
	logic [2:0]  last_slew;
	logic        ready;

	// cycles the raw pins have allowed the switch
	assign ready = !i_pins.en_n && i_pins.above_undervoltage_lockout && !i_pins.above_ovlo
		&& !i_pins.over_current && !i_pins.temp_hot;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n || !ready) begin
			ready_cnt <= '0;
		end else if (ready_cnt < DEBOUNCE) begin
			ready_cnt <= ready_cnt + 1;
		end
		if (!i_rst_n) begin
			last_slew <= SLEW_RESET;
		end else if (i_reg_req.write && i_reg_req.addr == ADDR_SLEW) begin
			last_slew <= i_reg_req.wdata[2:0];
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	sequence s_enable_off;
		i_pins.en_n [*6];
	endsequence
	sequence s_ov_seen;
		(!i_pins.en_n && i_pins.above_ovlo) [*6];
	endsequence
	sequence s_undervoltage_lockout_low;
		(!i_pins.en_n && !i_pins.above_undervoltage_lockout) [*6];
	endsequence
	sequence s_undervoltage_lockout_high;
		i_pins.above_undervoltage_lockout [*6];
	endsequence

	a_enable_off: assert property (s_enable_off |->
		!o_switch_on && !o_protect_enable && !o_detect_power)
		else $error("switch or protection active while disabled");
	a_debounce_wait: assert property ($rose(o_switch_on) |->
		ready_cnt >= DEBOUNCE)
		else $error("switch closed before debounce");
	a_ov_opens: assert property (s_ov_seen |-> !o_switch_on)
		else $error("switch on during overvoltage");
	a_undervoltage_lockout_holds: assert property (s_undervoltage_lockout_low |-> !o_switch_on)
		else $error("switch on below undervoltage");
	a_detect_exit: assert property (s_undervoltage_lockout_high |->
		!o_detect_power && !o_probe_on)
		else $error("detection active above undervoltage");
	a_probe_start: assert property ($rose(o_probe_on) |->
		o_detect_power && o_probe_current != PROBE_OFF)
		else $error("probe on without current or power");
	a_slew_follows: assert property (
		i_reg_req.write && i_reg_req.addr == ADDR_SLEW
		|-> ##2 o_slew_select == last_slew)
		else $error("slew output not the written code");
	a_alt_force: assert property (
		i_reg_req.write && i_reg_req.addr == ADDR_ALT
		&& i_reg_req.wdata[1:0] == ALT_14V
		|-> ##[1:3] o_trip.level == LEVEL_14V && !o_trip.use_pin)
		else $error("alternate threshold not forced");
	a_trim_source: assert property (o_trip.use_pin |->
		!o_trip.use_trim)
		else $error("trim applied to pin threshold");
	a_trim_taken: assert property (
		i_reg_req.write && i_reg_req.addr == ADDR_TRIP
		|-> ##2 o_trip.use_trim && !o_trip.use_pin)
		else $error("register threshold not trimmed");
endmodule : ovp_switch_control_props

bind ovp_switch_control ovp_switch_control_props #(.DEBOUNCE(DEBOUNCE)) u_props (
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pins(i_pins),
	.i_adc_valid(i_adc_valid), .i_adc_result(i_adc_result),
	.i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
	.o_reg_rvalid(o_reg_rvalid), .o_switch_on(o_switch_on),
	.o_slew_select(o_slew_select), .o_protect_enable(o_protect_enable),
	.o_trip(o_trip), .o_detect_power(o_detect_power),
	.o_probe_on(o_probe_on), .o_probe_current(o_probe_current),
	.o_event(o_event)
);

/* File: test/ovp_host_model.sv */
// host model driving the register strobe port
`timescale 1ns/1ps
module ovp_host_model
	import ovp_switch_pkg::*;
(
	// clock
	input  wire logic       i_clock,
	// read answer
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rvalid,
	// request
	output reg_req_t        o_req
);
	initial o_req = '0;

	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		o_req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
		@(posedge i_clock);
		o_req <= '0;
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		@(posedge i_clock);
		o_req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_clock);
		o_req <= '0;
		ok = 1'b0;
		d = 8'h00;
		repeat (3) begin
			@(posedge i_clock);
			if (i_rvalid === 1'b1 && !ok) begin
				d = i_rdata;
				ok = 1'b1;
			end
		end
	endtask : read_reg
endmodule : ovp_host_model

/* File: test/ovp_switch_control_test.sv */
// self-checking bench for the overvoltage switch control
`timescale 1ns/1ps
module ovp_switch_control_test
	import ovp_switch_pkg::*;
;
	localparam int DEB = 20;
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} row_t;
	logic       i_clock;
	logic       i_rst_n;
	logic       i_adc_valid;
	logic [7:0] i_adc_result;
	pins_t      i_pins;
	reg_req_t   i_reg_req;
	logic [7:0] rdata;
	logic       rvalid;
	logic       sw_on;
	logic [2:0] slew;
	logic       prot;
	trip_cfg_t  trip;
	logic       det_pwr;
	logic       probe;
	logic [3:0] probe_cur;
	logic       evt;
	logic [7:0] rd;
	logic       ok;
	logic [2:0] lv;
	logic [7:0] flg[3];
	row_t       rows[8];
	int         fails;
	int         total_checks;
	int         evts;
	int         e0;
	int         n;

	ovp_switch_control #(.DEBOUNCE(DEB)) DUT (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pins(i_pins),
		.i_adc_valid(i_adc_valid), .i_adc_result(i_adc_result),
		.i_reg_req(i_reg_req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.o_switch_on(sw_on), .o_slew_select(slew), .o_protect_enable(prot),
		.o_trip(trip), .o_detect_power(det_pwr), .o_probe_on(probe),
		.o_probe_current(probe_cur), .o_event(evt)
	);
	ovp_host_model host (
		.i_clock(i_clock), .i_rdata(rdata), .i_rvalid(rvalid),
		.o_req(i_reg_req)
	);

	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	always @(posedge i_clock) if (evt === 1'b1) evts++;

	task automatic miss(input string m);
		fails++;
		$display("unexpected at %0t: %s", $time, m);
	endtask : miss
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) miss($sformatf("got %h want %h", g, e));
	endtask : chk_byte
	task automatic chk_bit(input logic g, input logic e);
		total_checks++;
		if (g !== e) miss("wrong level");
	endtask : chk_bit
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host.read_reg(a, rd, ok);
		chk_bit(ok, 1'b1);
		if (ok !== 1'b1) tally_and_finish();
		chk_byte(rd, e);
	endtask : rd_chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish
	task automatic wait_on(input int s, input logic v, input int lim);
		n = 0;
		while ((s == 0 ? sw_on : probe) !== v) begin
			@(posedge i_clock);
			n++;
			if (n > lim) begin
				miss("wait expired");
				tally_and_finish();
			end
		end
	endtask : wait_on
	task automatic do_reset();
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		repeat (20) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
	endtask : do_reset
	task automatic fault(input int f, input logic v);
		@(posedge i_clock);
		case (f)
			0: i_pins.above_ovlo <= v;
			1: begin
				i_pins.temp_hot <= v;
				i_pins.temp_cool <= !v;
			end
			default: begin
				i_pins.over_current <= v;
				i_pins.fully_on <= v;
			end
		endcase
	endtask : fault

	initial begin
		i_rst_n = 1'b0;
		i_pins = PINS_RESET;
		i_pins.adjust_valid = 1'b1;
		i_pins.temp_cool = 1'b1;
		i_adc_valid = 1'b0;
		i_adc_result = 8'h00;
		fails = 0;
		total_checks = 0;
		evts = 0;
		flg = '{8'h04, 8'h01, 8'h02};
		rows = '{'{1'b0, ADDR_SLEW, 8'h00, 8'h04},
			'{1'b0, ADDR_TRIP, 8'h00, 8'h30}, '{1'b0, ADDR_PROBE, 8'h00, 8'h00},
			'{1'b0, ADDR_TIMING, 8'h00, 8'h00}, '{1'b0, ADDR_FLAG, 8'h00, 8'h00},
			'{1'b1, ADDR_TRIP, 8'hFE, 8'h72}, '{1'b1, ADDR_TIMING, 8'hF5, 8'hF5},
			'{1'b1, 8'h0A, 8'h55, 8'h00}};
		do_reset();
		chk_bit(trip.use_pin, 1'b1);
		chk_bit(trip.use_trim, 1'b0);
		chk_byte({5'h00, slew}, {5'h00, SLEW_RESET});
		chk_bit(sw_on, 1'b0);
		foreach (rows[i]) begin
			if (rows[i].wr) host.write_reg(rows[i].addr, rows[i].wdata);
			rd_chk(rows[i].addr, rows[i].exp);
		end
		chk_bit(trip.use_trim, 1'b1);
		$display("register rows done");
		for (int c = 0; c < 8; c++) begin
			host.write_reg(ADDR_SLEW, 8'(c));
			host.write_reg(ADDR_TRIP, {1'b0, 3'(c), 2'b00, 2'(c)});
			rd_chk(ADDR_SLEW, 8'(c));
			chk_byte({5'h00, slew}, 8'(c));
			chk_byte({2'h0, trip.level, trip.trim}, 8'(c[1:0] * 8 + c));
		end
		for (int a = 1; a < 4; a++) begin
			host.write_reg(ADDR_ALT, 8'(a));
			lv = a == 2 ? LEVEL_10V : (a == 3 ? LEVEL_14V : 3'h3);
			rd_chk(ADDR_ALT, 8'(a));
			chk_byte({5'h00, trip.level}, {5'h00, lv});
		end
		host.write_reg(ADDR_ALT, 8'h00);
		$display("code tables done");
		i_pins.en_n <= 1'b0;
		i_pins.above_undervoltage_lockout <= 1'b1;
		wait_on(0, 1'b1, DEB + 12);
		chk_bit(n >= DEB && n <= DEB + 8, 1'b1);
		chk_bit(prot, 1'b1);
		for (int f = 0; f < 3; f++) begin
			repeat (3) @(posedge i_clock);
			e0 = evts;
			fault(f, 1'b1);
			repeat (8) @(posedge i_clock);
			chk_bit(sw_on, 1'b0);
			chk_bit(evts > e0, 1'b1);
			fault(f, 1'b0);
			repeat (4) @(posedge i_clock);
			rd_chk(ADDR_FLAG, flg[f]);
			rd_chk(ADDR_FLAG, 8'h00);
			wait_on(0, 1'b1, DEB + 12);
			$display("fault case %0d done", f);
		end
		host.write_reg(ADDR_ENABLE, 8'h80);
		i_pins.otg_source <= 1'b1;
		fault(1, 1'b1);
		repeat (8) @(posedge i_clock);
		chk_bit(sw_on, 1'b1);
		fault(1, 1'b0);
		rd_chk(ADDR_FLAG, 8'h01);
		i_pins.otg_source <= 1'b0;
		host.write_reg(ADDR_ENABLE, 8'h00);
		$display("otg case done");
		i_pins.above_undervoltage_lockout <= 1'b0;
		i_adc_valid <= 1'b1;
		i_adc_result <= 8'h20;
		repeat (6) @(posedge i_clock);
		chk_bit(sw_on, 1'b0);
		host.write_reg(ADDR_ENABLE, 8'h40);
		repeat (4) @(posedge i_clock);
		chk_bit(det_pwr, 1'b1);
		host.write_reg(ADDR_TIMING, 8'h00);
		host.write_reg(ADDR_TARGET, 8'h80);
		e0 = evts;
		host.write_reg(ADDR_PROBE, 8'h03);
		wait_on(1, 1'b1, 8);
		chk_byte({4'h0, probe_cur}, 8'h03);
		wait_on(1, 1'b0, 200 * US_CYCLES + 40);
		chk_bit(n >= 200 * US_CYCLES - 4, 1'b1);
		repeat (4) @(posedge i_clock);
		rd_chk(ADDR_STATUS, 8'h60);
		rd_chk(ADDR_RESULT, 8'h20);
		chk_bit(evts > e0, 1'b1);
		host.write_reg(ADDR_PROBE, 8'h00);
		host.write_reg(ADDR_PROBE, 8'h0F);
		wait_on(1, 1'b1, 8);
		i_pins.above_undervoltage_lockout <= 1'b1;
		repeat (6) @(posedge i_clock);
		chk_bit(det_pwr | probe, 1'b0);
		$display("detection case done");
		i_pins.en_n <= 1'b1;
		repeat (6) @(posedge i_clock);
		chk_byte({5'h00, sw_on, prot, det_pwr}, 8'h00);
		i_pins.adjust_valid <= 1'b0;
		do_reset();
		chk_bit(trip.use_pin, 1'b0);
		chk_bit(trip.use_trim, 1'b0);
		chk_byte({5'h00, trip.level}, 8'h00);
		rd_chk(ADDR_SLEW, 8'h04);
		$display("second reset done");
		tally_and_finish();
	end
endmodule : ovp_switch_control_test
